// ---- sts_pkg.sv ----
// sts_pkg: constants, types and helpers shared by the sensor tracker supervisor
// assumes a single 40 MHz device clock and a synchronous active-high reset
`default_nettype none

package sts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_FREQ_HZ     = 40_000_000;
  localparam int unsigned STG_TIME_NS     = 100_000;  // ground short detect time
  localparam int unsigned STG_CYCLES      = (STG_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int          STG_CNT_W       = 12;
  localparam int unsigned TSD_OFF_TIME_MS = 1000;     // least thermal off time
  localparam int unsigned TSD_OFF_CYCLES  = TSD_OFF_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int          TSD_CNT_W       = 26;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_LIVE   = 4'h8;

  // reset values
  localparam logic [1:0] CTRL_RST   = 2'h0;
  localparam logic [6:0] STATUS_RST = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // device operating state, driven by the device state machine
  typedef enum logic [2:0]
  {
    OP_INIT     = 3'h0,
    OP_NORMAL   = 3'h1,
    OP_SLEEP    = 3'h2,
    OP_WAKE     = 3'h3,
    OP_STANDBY  = 3'h4,
    OP_SAFE_OFF = 3'h5
  } sts_op_t;

  // comparator and sensor pins, all asynchronous
  typedef struct packed
  {
    logic       tshut;   // chip above shutdown temperature
    logic       twarn;   // chip above pre-warning temperature
    logic       ref_on;  // reference output present
    logic [1:0] uv;      // tracker output under-voltage
    logic [1:0] ov;      // tracker output over-voltage
  } sts_pins_t;

  // sticky status flags, status register bits 6:0
  typedef struct packed
  {
    logic       twarn;   // bit 6
    logic [1:0] uv;      // bits 5:4
    logic [1:0] ov;      // bits 3:2
    logic [1:0] stg;     // bits 1:0
  } sts_flags_t;

  // live view register, bits 11:0
  typedef struct packed
  {
    sts_op_t    op;      // bits 11:9
    logic       tshut;   // bit 8
    logic [1:0] ov;      // bits 7:6
    logic [1:0] uv;      // bits 5:4
    logic       ref_on;  // bit 3
    logic       tsd;     // bit 2
    logic [1:0] trk_on;  // bits 1:0
  } sts_live_t;

  // trackers may run only in these states
  function automatic logic op_allows_on(input sts_op_t op);
    return (op == OP_INIT) || (op == OP_NORMAL) || (op == OP_SLEEP) || (op == OP_WAKE);
  endfunction

endpackage

`default_nettype wire

// ---- sts_trk_mon.sv ----
// sts_trk_mon: event detection and ground short timer for one tracker
// assumes synchronised comparator levels on clk_i
`timescale 1ns/1ps
`default_nettype none

module sts_trk_mon
  import sts_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic trk_on_i,
  input  wire logic ov_i,
  input  wire logic uv_i,
  output var  logic ev_ov_o,
  output var  logic ev_uv_o,
  output var  logic ev_stg_o
);

  localparam logic [STG_CNT_W-1:0] STG_LAST = STG_CNT_W'(STG_CYCLES);

  logic                 ov_d;
  logic                 uv_d;
  logic [STG_CNT_W-1:0] stg_cnt;
  logic                 uv_live;

  ////////////////////////////////////////////////////////////////////////////
  // under-voltage only counts while the tracker is driven
  assign uv_live  = uv_i & trk_on_i;
  assign ev_ov_o  = ov_i & ~ov_d;
  assign ev_uv_o  = uv_live & ~uv_d;
  assign ev_stg_o = uv_live & (stg_cnt == STG_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // edge history and ground short timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ov_d    <= 1'b0;
      uv_d    <= 1'b0;
      stg_cnt <= '0;
    end
    else
    begin
      ov_d <= ov_i;
      uv_d <= uv_live;
      if (!uv_live)
        stg_cnt <= '0;
      else if (stg_cnt != STG_LAST)
        stg_cnt <= stg_cnt + STG_CNT_W'(1);
    end
  end

endmodule // sts_trk_mon

`default_nettype wire

// ---- sts_supervisor.sv ----
// sts_supervisor: supervision of the two sensor-supply trackers
// assumes op_state_i from device logic on clk_i, comparator pins asynchronous,
// classic Wishbone master on clk_i
//
// Operation
// - an output over-voltage switches its tracker off, sets its flag and pulses the interrupt.
// - an output under-voltage while its tracker is on sets its flag and pulses the interrupt.
// - a tracker stays on while an under-voltage is no longer than the ground short time.
// - an under-voltage beyond the ground short time switches off, sets its flag and pulses the interrupt.
// - a short to battery above the over-voltage threshold switches off and sets the over-voltage flag.
// - a crossing of the temperature pre-warning sets the warning flag and pulses the interrupt.
// - a thermal shutdown turns both trackers off and keeps them off for at least one second.
// - both trackers are held off in standby and safe-off states.
// - in init, normal, sleep and wake each tracker follows its host-written enable bit.
// - a tracker enabled while the reference is off sees an under-voltage and interrupts.
// - entering safe-off pulls the reset output low and turns all supplies off.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sts_supervisor
  import sts_pkg::*;
#(
  parameter int unsigned TSD_HOLD_CYCLES = TSD_OFF_CYCLES
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // device state and sensors
  input  wire sts_op_t     op_state_i,
  input  wire sts_pins_t   pins_i,
  // supply control
  output var  logic [1:0]  tracker_output_en_o,
  output var  logic        reset_output_n_o,
  output var  logic        int_pulse_o
);

  localparam logic [TSD_CNT_W-1:0] TSD_LOAD = TSD_CNT_W'(TSD_HOLD_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  sts_pins_t             pin_meta;
  sts_pins_t             pin_sync;
  logic                  twarn_d;
  logic [1:0]            ctrl_en;
  sts_flags_t            flags;
  sts_flags_t            next_flags;
  sts_flags_t            flag_set;
  sts_flags_t            flag_clr;
  logic [TSD_CNT_W-1:0]  tsd_cnt;
  logic                  tsd_active;
  logic                  state_allows;
  logic                  safe_off;
  logic [1:0]            uv_qual;
  logic [1:0]            ev_ov;
  logic [1:0]            ev_uv;
  logic [1:0]            ev_stg;
  logic                  ev_twarn;
  logic                  any_event;
  logic [1:0]            next_trk_en;
  logic                  wb_req;
  logic                  wb_wr;
  logic                  wr_lane0;
  logic                  hit_ctrl;
  logic                  hit_status;
  logic                  hit_live;
  sts_live_t             live;
  logic [31:0]           rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser for comparator and sensor pins

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pins_i;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-tracker monitors

  // with no reference the tracker output sits at zero volts
  assign uv_qual = pin_sync.uv | {2{~pin_sync.ref_on}};

  for (genvar i = 0; i < 2; i++)
  begin : g_trk
    sts_trk_mon u_mon
    (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .trk_on_i (tracker_output_en_o[i]),
      .ov_i     (pin_sync.ov[i]),
      .uv_i     (uv_qual[i]),
      .ev_ov_o  (ev_ov[i]),
      .ev_uv_o  (ev_uv[i]),
      .ev_stg_o (ev_stg[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // temperature warning edge

  assign ev_twarn = pin_sync.twarn & ~twarn_d;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      twarn_d <= 1'b0;
    else
      twarn_d <= pin_sync.twarn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal shutdown hold timer

  // reload while hot, then count the hold time down
  assign tsd_active = pin_sync.tshut | (tsd_cnt != '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tsd_cnt <= '0;
    else if (pin_sync.tshut)
      tsd_cnt <= TSD_LOAD;
    else if (tsd_cnt != '0)
      tsd_cnt <= tsd_cnt - TSD_CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags, write one to clear, set beats clear

  assign flag_set.stg   = ev_stg;
  assign flag_set.ov    = ev_ov;
  assign flag_set.uv    = ev_uv;
  assign flag_set.twarn = ev_twarn;

  assign flag_clr   = (wb_wr && hit_status && wr_lane0) ? sts_flags_t'(wb_dat_i[6:0]) : sts_flags_t'(STATUS_RST);
  assign next_flags = sts_flags_t'((flags & ~flag_clr) | flag_set);
  assign any_event  = |flag_set;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags <= sts_flags_t'(STATUS_RST);
    else
      flags <= next_flags;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pulse, one cycle per cycle with new events

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_pulse_o <= 1'b0;
    else
      int_pulse_o <= any_event;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tracker enables

  assign state_allows = op_allows_on(op_state_i);
  assign safe_off     = (op_state_i == OP_SAFE_OFF);

  // an over-voltage tracker stays off until its flag is cleared and the fault is gone, a ground-shorted one until its flag is cleared
  assign next_trk_en = ctrl_en
                     & {2{state_allows}}
                     & {2{~safe_off}}
                     & {2{~tsd_active}}
                     & ~ev_ov & ~flags.ov & ~pin_sync.ov
                     & ~ev_stg & ~flags.stg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tracker_output_en_o <= 2'h0;
    else
      tracker_output_en_o <= next_trk_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset output, low in safe-off and during reset

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reset_output_n_o <= 1'b0;
    else
      reset_output_n_o <= ~safe_off;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr      = wb_req & wb_we_i;
  assign wr_lane0   = wb_sel_i[0];
  assign hit_ctrl   = (wb_adr_i == ADR_CTRL);
  assign hit_status = (wb_adr_i == ADR_STATUS);
  assign hit_live   = (wb_adr_i == ADR_LIVE);

  ////////////////////////////////////////////////////////////////////////////
  // live view of the block state

  assign live.op     = op_state_i;
  assign live.tshut  = pin_sync.tshut;
  assign live.ov     = pin_sync.ov;
  assign live.uv     = pin_sync.uv;
  assign live.ref_on = pin_sync.ref_on;
  assign live.tsd    = tsd_active;
  assign live.trk_on = tracker_output_en_o;

  // read mux, unmapped addresses read zero
  assign rd_data = hit_ctrl   ? {30'h0000_0000, ctrl_en} :
                   hit_status ? {25'h000_0000, flags} :
                   hit_live   ? {20'h0_0000, live} :
                                32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // host enable configuration

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_en <= CTRL_RST;
    else if (wb_wr && hit_ctrl && wr_lane0)
      ctrl_en <= wb_dat_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle answer: ack and data one edge after the request is seen

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= rd_data;
    end
  end

endmodule // sts_supervisor

`default_nettype wire

// ---- sts_supervisor_monitor.sv ----
// sts_supervisor_monitor: port checks on the tracker supervisor
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sts_supervisor_monitor
  import sts_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire sts_op_t    op_state_i,
  input wire sts_pins_t  pins_i,
  input wire logic [1:0] tracker_output_en_o,
  input wire logic       reset_output_n_o,
  input wire logic       int_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [11:0] uv_run;
  // run length of under-voltage on a live tracker 0
  always_ff @(posedge clk_i)
    uv_run <= (rst_i || !pins_i.uv[0] || !tracker_output_en_o[0]) ? 12'h000 : uv_run + 12'h001;
  ////////////////////////////////////////////////////////////////////////////
  property p_ov;
    $rose(pins_i.ov[0]) |-> ##[1:4] (!tracker_output_en_o[0] && int_pulse_o);
  endproperty
  a_ov: assert property (p_ov) else $error("ov left tracker on");
  property p_uv;
    $rose(pins_i.uv[1]) && tracker_output_en_o[1] |-> ##[1:4] int_pulse_o;
  endproperty
  a_uv: assert property (p_uv) else $error("uv gave no interrupt");
  property p_stg;
    uv_run == 12'hF96 |-> ##[1:30] (!tracker_output_en_o[0] || !pins_i.uv[0]);
  endproperty
  a_stg: assert property (p_stg) else $error("ground short left tracker on");
  property p_warn;
    $rose(pins_i.twarn) |-> ##[1:4] int_pulse_o;
  endproperty
  a_warn: assert property (p_warn) else $error("warning gave no interrupt");
  property p_tsd;
    pins_i.tshut [*3] |=> tracker_output_en_o == 2'h0;
  endproperty
  a_tsd: assert property (p_tsd) else $error("shutdown left a tracker on");
  property p_tsd_hold;
    $fell(pins_i.tshut) |=> (tracker_output_en_o == 2'h0) [*8];
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("thermal hold too short");
  property p_off_state;
    !op_allows_on(op_state_i) |=> tracker_output_en_o == 2'h0;
  endproperty
  a_off_state: assert property (p_off_state) else $error("tracker on in off state");
  property p_safe;
    op_state_i == OP_SAFE_OFF |=> !reset_output_n_o && tracker_output_en_o == 2'h0;
  endproperty
  a_safe: assert property (p_safe) else $error("safe-off not applied");
endmodule // sts_supervisor_monitor
bind sts_supervisor sts_supervisor_monitor i_sts_supervisor_monitor
(
  .clk_i              (clk_i),
  .rst_i              (rst_i),
  .op_state_i         (op_state_i),
  .pins_i             (pins_i),
  .tracker_output_en_o(tracker_output_en_o),
  .reset_output_n_o   (reset_output_n_o),
  .int_pulse_o        (int_pulse_o)
);
`default_nettype wire

// ---- sts_host.sv ----
// sts_host: wishbone host that programs and reads the supervisor
// assumes its task is called by the bench just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module sts_host
(
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic        wb_cyc_o,
  output var  logic        wb_we_o,
  output var  logic [3:0]  wb_adr_o,
  output var  logic [31:0] wb_dat_o
);
  // idle bus
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // one classic cycle, held until ack; reads or writes any register
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!wb_ack_i && n < 16);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    if (n >= 16)
    begin
      sts_supervisor_tb.failures++;
      sts_supervisor_tb.report_and_stop();
    end
  endtask
endmodule // sts_host
`default_nettype wire

// ---- sts_supervisor_tb.sv ----
// sts_supervisor_tb: self-checking bench for the tracker supervisor
// assumes sts_host as register master and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module sts_supervisor_tb
  import sts_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, we, ack, rst_n, irq;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  logic [1:0]  en;
  sts_op_t     op;
  sts_pins_t   pins;
  int          failures = 0;
  int          checks_done = 0;
  always #12.5 clk = ~clk;
  sts_supervisor #(.TSD_HOLD_CYCLES(50)) i_sts_supervisor
  (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .op_state_i(op),
    .pins_i(pins), .tracker_output_en_o(en), .reset_output_n_o(rst_n), .int_pulse_o(irq)
  );
  sts_host i_sts_host
  (
    .clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_we_o(we),
    .wb_adr_o(adr), .wb_dat_o(wdat)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // wait n edges and count the interrupt pulses seen at them
  task automatic wt_irq(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (irq === 1'b1)
        c++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_sts_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_sts_host.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("en", 32'h0, {30'h0, en});
    rd_chk("ctrl", ADR_CTRL, 32'h0);
    rd_chk("status", ADR_STATUS, 32'h0);
    rd_chk("unmapped", 4'hC, 32'h0);
  endtask
  task automatic t_modes();
    wr(ADR_CTRL, 32'h1);
    wt(3);
    chk("en one", 32'h1, {30'h0, en});
    wr(ADR_CTRL, 32'h3);
    for (int s = 0; s < 6; s++)
    begin
      op <= sts_op_t'(s);
      wt(3);
      chk("en mode", (s < 4) ? 32'h3 : 32'h0, {30'h0, en});
      chk("reset out", (s == 5) ? 32'h0 : 32'h1, {31'h0, rst_n});
    end
    op <= OP_NORMAL;
    wt(3);
    rd_chk("live", ADR_LIVE, 32'h20B);
  endtask
  task automatic t_ov();
    int c;
    pins.ov[0] <= 1'b1;
    wt_irq(5, c);
    chk("ov irq", 32'h1, c);
    chk("ov en", 32'h2, {30'h0, en});
    rd_chk("ov flag", ADR_STATUS, 32'h4);
    wt(20);
    chk("ov held", 32'h2, {30'h0, en});
    pins.ov[0] <= 1'b0;
    wr(ADR_STATUS, 32'h4);
    wt(5);
    chk("ov back", 32'h3, {30'h0, en});
  endtask
  task automatic t_uv();
    pins.uv[1] <= 1'b1;
    wt(3000);
    pins.uv[1] <= 1'b0;
    wt(2);
    pins.uv[1] <= 1'b1;
    wt(3000);
    chk("uv short", 32'h3, {30'h0, en});
    rd_chk("uv flag", ADR_STATUS, 32'h20);
    pins.uv[1] <= 1'b0;
    wr(ADR_STATUS, 32'h7F);
  endtask
  task automatic t_stg();
    pins.uv[0] <= 1'b1;
    wt(4100);
    chk("stg en", 32'h2, {30'h0, en});
    rd_chk("stg flag", ADR_STATUS, 32'h11);
    pins.uv[0] <= 1'b0;
    wt(3);
    wr(ADR_STATUS, 32'h7F);
    wt(5);
    chk("stg back", 32'h3, {30'h0, en});
  endtask
  task automatic t_temp();
    pins.twarn <= 1'b1;
    pins.tshut <= 1'b1;
    wt(10);
    chk("tsd en", 32'h0, {30'h0, en});
    rd_chk("warn flag", ADR_STATUS, 32'h40);
    pins.tshut <= 1'b0;
    pins.twarn <= 1'b0;
    wt(40);
    chk("tsd hold", 32'h0, {30'h0, en});
    wt(30);
    chk("tsd end", 32'h3, {30'h0, en});
    wr(ADR_STATUS, 32'h7F);
  endtask
  task automatic t_ref();
    pins.ref_on <= 1'b0;
    wt(10);
    rd_chk("ref uv", ADR_STATUS, 32'h30);
    pins.ref_on <= 1'b1;
    wr(ADR_STATUS, 32'h7F);
  endtask
  // main sequence
  initial
  begin
    op = OP_NORMAL;
    pins = sts_pins_t'(7'h10);
    wt(4);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_ov();
    t_uv();
    t_stg();
    t_temp();
    t_ref();
    report_and_stop();
  end
endmodule // sts_supervisor_tb
`default_nettype wire
